// File: design/acsr_top.sv
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module acsr_top #(
    parameter logic [31:0] IMPL_MASK = 32'hffff_ffff, // implemented channels
    parameter int          RES_W     = 12             // conversion result width
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [7:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic [31:0]           dat_o,
    output logic                  ack_o,
    // converter core events
    input  wire logic             conv_done_i,
    input  wire logic [4:0]       conv_channel_i,
    input  wire logic [RES_W-1:0] conv_result_i,
    input  wire logic [RES_W-1:0] thresh_lo_i,
    input  wire logic [RES_W-1:0] thresh_hi_i,
    // analog multiplexer steering
    output logic [4:0]            pos_sel_o,
    output logic [2:0]            neg_sel_o,
    output logic                  set_b_active_o,
    output logic                  charge_meas_connect_o,
    output logic [31:0]           channel_scan_select_o,
    output logic [31:0]           channel_charge_meas_enable_o,
    output logic [31:0]           channel_compare_hit_o,
    // interrupt
    output logic                  irq_o
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [15:0]                 chs_ff;   // sample_input_select
    logic [31:0]                 scan_ff;  // scan map
    logic [31:0]                 ctm_ff;   // charge enable map
    logic [31:0]                 hit_ff;   // compare hit map
    logic [acsr_pkg::CTRL_W-1:0] ctrl_ff;  // alternate enable and compare mode
    logic [acsr_pkg::EVT_W-1:0]  ists_ff;  // sticky events
    logic [acsr_pkg::EVT_W-1:0]  imask_ff; // event mask
    logic                        ack_ff;   // bus answer
    logic [31:0]                 dat_ff;   // read data
    logic                        irq_ff;   // interrupt level
    logic                        conn_ff;  // charge module on current channel

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    // a request is taken one cycle, answered the next
    wire acc_w = cyc_i && stb_i && !ack_ff;
    wire wr_w  = acc_w && we_i;
    wire rd_w  = acc_w && !we_i;
    wire hit_chs   = adr_i == acsr_pkg::OFS_SAMPLE_INPUT_SELECT;
    wire hit_hh    = adr_i == acsr_pkg::OFS_COMPARE_HIT_HIGH;
    wire hit_hl    = adr_i == acsr_pkg::OFS_COMPARE_HIT_LOW;
    wire hit_sh    = adr_i == acsr_pkg::OFS_SCAN_SELECT_HIGH;
    wire hit_sl    = adr_i == acsr_pkg::OFS_SCAN_SELECT_LOW;
    wire hit_ch    = adr_i == acsr_pkg::OFS_CHARGE_MEAS_EN_HIGH;
    wire hit_cl    = adr_i == acsr_pkg::OFS_CHARGE_MEAS_EN_LOW;
    wire hit_ctrl  = adr_i == acsr_pkg::OFS_CONVERT_CONTROL;
    wire hit_ists  = adr_i == acsr_pkg::OFS_IRQ_STATUS;
    wire hit_imask = adr_i == acsr_pkg::OFS_IRQ_MASK;

    // ------------------------------------------------------------
    // compare and alternation
    // ------------------------------------------------------------
    wire match_w; // result meets the compare mode
    wire [1:0] cmode_w = ctrl_ff[acsr_pkg::CTRL_CM +: 2];
    wire       alt_w   = ctrl_ff[acsr_pkg::CTRL_ALT];

    acsr_cmp #(
        .RES_W (RES_W)
    ) u_cmp (
        .mode_i   (cmode_w),
        .result_i (conv_result_i),
        .lo_i     (thresh_lo_i),
        .hi_i     (thresh_hi_i),
        .match_o  (match_w)
    );

    acsr_alt u_alt (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .alt_en_i    (alt_w),
        .conv_done_i (conv_done_i),
        .sel_word_i  (chs_ff),
        .pos_sel_o   (pos_sel_o),
        .neg_sel_o   (neg_sel_o),
        .set_b_o     (set_b_active_o)
    );

    // ------------------------------------------------------------
    // next values of the channel maps
    // ------------------------------------------------------------
    // absent channels never store a one
    wire [31:0] nxt_scan = IMPL_MASK & {
        (wr_w && hit_sh) ? acsr_pkg::merge16(scan_ff[31:16], dat_i, sel_i) : scan_ff[31:16],
        (wr_w && hit_sl) ? acsr_pkg::merge16(scan_ff[15:0], dat_i, sel_i)  : scan_ff[15:0]};
    wire [15:0] nxt_ctm_h = (wr_w && hit_ch) ? acsr_pkg::merge16(ctm_ff[31:16], dat_i, sel_i)
                                             : ctm_ff[31:16];
    wire [15:0] nxt_ctm_l = (wr_w && hit_cl) ? acsr_pkg::merge16(ctm_ff[15:0], dat_i, sel_i)
                                             : ctm_ff[15:0];
    // charge enables of absent channels held at zero
    wire [31:0] nxt_ctm = IMPL_MASK & {nxt_ctm_h, nxt_ctm_l};

    // every positive code is stored; the core maps codes beyond the
    // external inputs to its internal sources
    wire [15:0] nxt_chs = (wr_w && hit_chs) ? acsr_pkg::merge16(chs_ff, dat_i, sel_i) : chs_ff;

    // control word holds alternate enable and compare mode
    wire [15:0] ctrl_m  = acsr_pkg::merge16({13'h0, ctrl_ff}, dat_i, sel_i);
    wire [acsr_pkg::CTRL_W-1:0] nxt_ctrl = (wr_w && hit_ctrl) ? ctrl_m[acsr_pkg::CTRL_W-1:0]
                                                              : ctrl_ff;
    wire [15:0] mask_m  = acsr_pkg::merge16({14'h0, imask_ff}, dat_i, sel_i);
    wire [acsr_pkg::EVT_W-1:0] nxt_imask = (wr_w && hit_imask) ? mask_m[acsr_pkg::EVT_W-1:0]
                                                               : imask_ff;

    // ------------------------------------------------------------
    // compare hits
    // ------------------------------------------------------------
    // valid match on a finished conversion marks its channel
    wire        hit_evt  = conv_done_i && match_w;
    wire [31:0] hit_set  = IMPL_MASK & ({31'h0, hit_evt} << conv_channel_i);
    // a read of a hit word clears it, a simultaneous set wins
    wire [31:0] hit_clr  = {{16{rd_w && hit_hh}}, {16{rd_w && hit_hl}}};
    wire [31:0] nxt_hit  = (hit_ff & ~hit_clr) | hit_set;

    // ------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------
    wire [acsr_pkg::EVT_W-1:0] evt_w    = {conv_done_i, hit_evt};
    wire [acsr_pkg::EVT_W-1:0] ists_clr = {acsr_pkg::EVT_W{rd_w && hit_ists}};
    wire [acsr_pkg::EVT_W-1:0] nxt_ists = (ists_ff & ~ists_clr) | evt_w;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire [15:0] rd_mux = hit_chs   ? chs_ff :
                         hit_hh    ? hit_ff[31:16] :
                         hit_hl    ? hit_ff[15:0] :
                         hit_sh    ? scan_ff[31:16] :
                         hit_sl    ? scan_ff[15:0] :
                         hit_ch    ? ctm_ff[31:16] :
                         hit_cl    ? ctm_ff[15:0] :
                         hit_ctrl  ? {13'h0, ctrl_ff} :
                         hit_ists  ? {14'h0, ists_ff} :
                         hit_imask ? {14'h0, imask_ff} : 16'h0000;

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    // power-on values are zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chs_ff   <= acsr_pkg::RST_WORD16;
            scan_ff  <= acsr_pkg::RST_MAP32;
            ctm_ff   <= acsr_pkg::RST_MAP32;
            ctrl_ff  <= '0;
            imask_ff <= '0;
        end
        else
        begin
            chs_ff   <= nxt_chs;
            scan_ff  <= nxt_scan;
            ctm_ff   <= nxt_ctm;
            ctrl_ff  <= nxt_ctrl;
            imask_ff <= nxt_imask;
        end
    end

    // status: hit map and sticky events
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            hit_ff  <= acsr_pkg::RST_MAP32;
            ists_ff <= '0;
        end
        else
        begin
            hit_ff  <= nxt_hit;
            ists_ff <= nxt_ists;
        end
    end

    // bus answer, every address acknowledged, unmapped reads zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= acc_w;
            dat_ff <= rd_w ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end

    // interrupt level and charge module connection
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_ff  <= 1'b0;
            conn_ff <= 1'b0;
        end
        else
        begin
            irq_ff  <= |(nxt_ists & nxt_imask);
            // connect only when the selected channel is enabled
            conn_ff <= ctm_ff[pos_sel_o];
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ack_o                        = ack_ff;
    assign dat_o                        = dat_ff;
    assign irq_o                        = irq_ff;
    assign charge_meas_connect_o        = conn_ff;
    assign channel_scan_select_o        = scan_ff;
    assign channel_charge_meas_enable_o = ctm_ff;
    assign channel_compare_hit_o        = hit_ff;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_single_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus answer not a single cycle");
    absent_zero_a: assert property (((scan_ff | ctm_ff | hit_ff) & ~IMPL_MASK) == 32'h0)
        else $error("absent channel bit set");
    hit_mark_a: assert property (conv_done_i && match_w && IMPL_MASK[conv_channel_i]
        |=> hit_ff[$past(conv_channel_i)])
        else $error("compare hit not recorded");
    less_mode_a: assert property (cmode_w == 2'b00 && conv_result_i < thresh_lo_i
        |-> match_w)
        else $error("less than mode missed a match");
    window_mode_a: assert property (cmode_w == 2'b11 && conv_result_i >= thresh_lo_i
        && conv_result_i <= thresh_hi_i |-> !match_w)
        else $error("outside mode matched inside window");
    reset_zero_a: assert property (disable iff (1'b0) $past(rst_i)
        |-> chs_ff == 16'h0000 && scan_ff == 32'h0 && ctm_ff == 32'h0)
        else $error("writable bits not zero after reset");
    charge_low_a: assert property (wr_w && hit_cl && sel_i == 4'h3
        |=> ctm_ff[15:0] == ($past(dat_i[15:0]) & IMPL_MASK[15:0]))
        else $error("low charge enable word not stored");
    charge_conn_a: assert property (ctm_ff == 32'h0 && $past(ctm_ff) == 32'h0
        |-> !charge_meas_connect_o)
        else $error("charge module connected while disabled");
    select_store_a: assert property (wr_w && hit_chs && sel_i == 4'h3 && !alt_w
        |=> chs_ff == $past(dat_i[15:0]) ##1 pos_sel_o == chs_ff[4:0])
        else $error("set a positive select not applied");

    // interrupt level tracks unmasked sticky events
    irq_level_a: assert property (irq_o == |(ists_ff & imask_ff))
        else $error("interrupt level differs from unmasked status");
    hit_clear_a: assert property (rd_w && hit_hl && !hit_evt
        |=> hit_ff[15:0] == 16'h0000)
        else $error("compare hit word not cleared by read");
    // finished conversion leaves a sticky event
    done_sticky_a: assert property (conv_done_i |=> ists_ff[acsr_pkg::EVT_DONE])
        else $error("conversion done event not recorded");
    // status read with no new event empties it
    status_clear_a: assert property (rd_w && hit_ists && !conv_done_i |=> ists_ff == '0)
        else $error("event status not cleared by read");
    steer_b_a: assert property (set_b_active_o
        |-> pos_sel_o == $past(chs_ff[12:8]) && neg_sel_o == $past(chs_ff[15:13]))
        else $error("set b codes not on the multiplexer outputs");
endmodule
`default_nettype wire

// File: design/acsr_pkg.sv
`default_nettype none
package acsr_pkg;

    // ------------------------------------------------------------
    // register byte addresses on the bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SAMPLE_INPUT_SELECT = 8'h00; // set a/b input selections
    localparam logic [7:0] OFS_COMPARE_HIT_HIGH    = 8'h04; // hit map, channels 31:16
    localparam logic [7:0] OFS_COMPARE_HIT_LOW     = 8'h08; // hit map, channels 15:0
    localparam logic [7:0] OFS_SCAN_SELECT_HIGH    = 8'h0c; // scan map, channels 31:16
    localparam logic [7:0] OFS_SCAN_SELECT_LOW     = 8'h10; // scan map, channels 15:0
    localparam logic [7:0] OFS_CHARGE_MEAS_EN_HIGH = 8'h14; // charge enables 31:16
    localparam logic [7:0] OFS_CHARGE_MEAS_EN_LOW  = 8'h18; // charge enables 15:0
    localparam logic [7:0] OFS_CONVERT_CONTROL     = 8'h1c; // alternate enable, compare mode
    localparam logic [7:0] OFS_IRQ_STATUS          = 8'h20; // sticky events, clear on read
    localparam logic [7:0] OFS_IRQ_MASK            = 8'h24; // event enables

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int NEG_B_LO  = 13; // set_b_negative_select 15:13
    localparam int POS_B_LO  = 8;  // set_b_positive_select 12:8
    localparam int NEG_A_LO  = 5;  // set_a_negative_select 7:5
    localparam int POS_A_LO  = 0;  // set_a_positive_select 4:0
    localparam int NEG_W     = 3;  // negative select width
    localparam int POS_W     = 5;  // positive select width
    localparam int CTRL_ALT  = 0;  // alternate_sample_enable
    localparam int CTRL_CM   = 1;  // compare_mode 2:1
    localparam int CTRL_W    = 3;  // control width
    localparam int EVT_HIT   = 0;  // valid compare match event
    localparam int EVT_DONE  = 1;  // conversion finished event
    localparam int EVT_W     = 2;  // event count

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WORD16 = 16'h0000; // all 16-bit registers
    localparam logic [31:0] RST_MAP32  = 32'h0000_0000; // all channel maps

    // compare mode encodings
    typedef enum logic [1:0] {
        ACSR_CM_LESS    = 2'b00,
        ACSR_CM_GREATER = 2'b01,
        ACSR_CM_INSIDE  = 2'b10,
        ACSR_CM_OUTSIDE = 2'b11
    } acsr_cmode_t;

    // byte-lane merge of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
        logic [15:0] res;
        res = old_v;
        if (sel[0])
        begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1])
        begin
            res[15:8] = wdat[15:8];
        end
        return res;
    endfunction

endpackage
`default_nettype wire

// File: design/acsr_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// threshold compare of one conversion result
module acsr_cmp #(
    parameter int RES_W = 12
) (
    // compare inputs
    input  wire logic [1:0]       mode_i,
    input  wire logic [RES_W-1:0] result_i,
    input  wire logic [RES_W-1:0] lo_i,
    input  wire logic [RES_W-1:0] hi_i,
    // verdict
    output logic                  match_o
);
    // ------------------------------------------------------------
    // relations
    // ------------------------------------------------------------
    wire lt_w  = result_i < lo_i;                     // below buffer value
    wire gt_w  = result_i > lo_i;                     // above buffer value
    wire in_w  = (result_i >= lo_i) && (result_i <= hi_i); // inside pair, ends included
    wire out_w = (result_i < lo_i) || (result_i > hi_i);   // outside pair

    assign match_o = (mode_i == acsr_pkg::ACSR_CM_LESS)    ? lt_w :
                     (mode_i == acsr_pkg::ACSR_CM_GREATER) ? gt_w :
                     (mode_i == acsr_pkg::ACSR_CM_INSIDE)  ? in_w : out_w;
endmodule
`default_nettype wire

// File: design/acsr_alt.sv
`timescale 1ns/1ps
`default_nettype none
// picks set a or set b selections for the analog multiplexers
module acsr_alt (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // control
    input  wire logic       alt_en_i,
    input  wire logic       conv_done_i,
    input  wire logic [15:0] sel_word_i,
    // multiplexer steering
    output logic [4:0]      pos_sel_o,
    output logic [2:0]      neg_sel_o,
    output logic            set_b_o
);
    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    // set a positive field
    wire [4:0] pos_a_w = sel_word_i[acsr_pkg::POS_A_LO +: acsr_pkg::POS_W];
    wire [2:0] neg_a_w = sel_word_i[acsr_pkg::NEG_A_LO +: acsr_pkg::NEG_W];
    wire [4:0] pos_b_w = sel_word_i[acsr_pkg::POS_B_LO +: acsr_pkg::POS_W];
    wire [2:0] neg_b_w = sel_word_i[acsr_pkg::NEG_B_LO +: acsr_pkg::NEG_W];

    logic set_b_ff; // set b in use for the next sample
    // toggle after each conversion when alternating
    wire nxt_set_b = alt_en_i ? (set_b_ff ^ conv_done_i) : 1'b0;

    // sample set phase
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            set_b_ff <= 1'b0;
        else
            set_b_ff <= nxt_set_b;
    end

    // registered multiplexer codes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pos_sel_o <= 5'h00;
            neg_sel_o <= 3'h0;
        end
        else
        begin
            pos_sel_o <= nxt_set_b ? pos_b_w : pos_a_w;
            neg_sel_o <= nxt_set_b ? neg_b_w : neg_a_w;
        end
    end
    assign set_b_o = set_b_ff;

    alt_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !alt_en_i |=> !set_b_o && pos_sel_o == $past(pos_a_w))
        else $error("set a not used while alternation off");
    alt_flip_a: assert property (@(posedge clk_i) disable iff (rst_i)
        alt_en_i && conv_done_i && !set_b_o |=> set_b_o && neg_sel_o == $past(neg_b_w))
        else $error("set b not taken after set a sample");
endmodule
`default_nettype wire

// File: verif/acsr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter core stand-in: one conversion event per bench request
module acsr_core_model (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // request from the bench
    input  wire logic        go_i,
    input  wire logic [4:0]  ch_i,
    input  wire logic [11:0] res_i,
    // event towards the block
    output logic             conv_done_o,
    output logic [4:0]       conv_channel_o,
    output logic [11:0]      conv_result_o
);
    // one-cycle done pulse; channel and result scramble between events
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            conv_done_o    <= 1'b0;
            conv_channel_o <= 5'h00;
            conv_result_o  <= 12'h000;
        end
        else
        begin
            conv_done_o    <= go_i;
            conv_channel_o <= go_i ? ch_i : ~conv_channel_o;
            conv_result_o  <= go_i ? res_i : ~conv_result_o;
        end
    end
endmodule
`default_nettype wire

// File: verif/test_adc_channel_select_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_channel_select_regs;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        clk_i, rst_i, cyc, stb, we, go, ack, done, irq, sb, cm;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat, q, scan, cme, hit;
    logic [4:0]  ch, cch, pos;
    logic [2:0]  neg;
    logic [11:0] res, cres, lo, hi;
    int          err_count, compares, cyc_cnt;
    logic [11:0] mt[4] = '{12'h032, 12'h096, 12'h096, 12'h0fa}; // matching results
    logic [11:0] nm[4] = '{12'h064, 12'h064, 12'h0fa, 12'h096}; // non-matching results

    acsr_top #(.IMPL_MASK(32'h00ff_ffff), .RES_W(12)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .conv_done_i(done),
        .conv_channel_i(cch), .conv_result_i(cres), .thresh_lo_i(lo), .thresh_hi_i(hi),
        .pos_sel_o(pos), .neg_sel_o(neg), .set_b_active_o(sb), .charge_meas_connect_o(cm),
        .channel_scan_select_o(scan), .channel_charge_meas_enable_o(cme),
        .channel_compare_hit_o(hit), .irq_o(irq));

    acsr_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .ch_i(ch), .res_i(res),
        .conv_done_o(done), .conv_channel_o(cch), .conv_result_o(cres));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h3;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            err_count++;
        end
        @(posedge clk_i);
    endtask

    // ask the core for one conversion, wait till the block took it
    task automatic conv(input logic [4:0] c, input logic [11:0] r);
        go  <= 1'b1;
        ch  <= c;
        res <= r;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    // print counts and verdict, end the run
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, sequence
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // cut a hang short
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 5000)
        begin
            err_count++;
            conclude();
        end
    end

    initial
    begin
        {rst_i, cyc, stb, we, go, adr, sel, dat, ch, res} = '0;
        rst_i = 1'b1;
        lo = 12'h064;
        hi = 12'h0c8;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        // every register and one unmapped place read zero
        for (int a = 0; a <= 8'h28; a += 4)
        begin
            wb(1'b0, a[7:0], 32'h0);
            chk(q, 32'h0);
        end
        $display("reset values done");
        // write then read back, absent channels and read-only words stay zero
        wb(1'b1, 8'h00, 32'h75a3);
        wb(1'b1, 8'h0c, 32'hffff);
        wb(1'b1, 8'h10, 32'hffff);
        wb(1'b1, 8'h14, 32'hffff);
        wb(1'b1, 8'h18, 32'h0008);
        wb(1'b1, 8'h04, 32'hffff);
        wb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h75a3);
        wb(1'b0, 8'h0c, 32'h0);
        chk(q, 32'h00ff);
        wb(1'b0, 8'h14, 32'h0);
        chk(q, 32'h00ff);
        wb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0);
        chk(scan, 32'h00ff_ffff);
        chk(cme, 32'h00ff_0008);
        chk({pos, neg}, {5'h03, 3'h5});
        chk(cm, 1'b1);
        $display("register map done");
        // alternate between set a and set b
        wb(1'b1, 8'h1c, 32'h1);
        conv(5'd3, 12'h064);
        chk({sb, pos, neg}, {1'b1, 5'h15, 3'h3});
        conv(5'd3, 12'h064);
        chk({sb, pos, neg}, {1'b0, 5'h03, 3'h5});
        $display("alternation done");
        // every compare mode, one miss and one hit each
        for (int m = 0; m < 4; m++)
        begin
            wb(1'b1, 8'h1c, {29'h0, m[1:0], 1'b0});
            conv(5'd3, nm[m]);
            chk(hit, 32'h0);
            conv(5'd2, mt[m]);
            chk(hit, 32'h4);
            wb(1'b0, 8'h08, 32'h0);
            chk(q, 32'h4);
            chk(hit, 32'h0);
        end
        $display("compare modes done");
        // interrupt: masked event stays quiet, unmasked one raises, read clears
        wb(1'b1, 8'h24, 32'h1);
        wb(1'b0, 8'h20, 32'h0);
        conv(5'd3, nm[3]);
        chk(irq, 1'b0);
        conv(5'd2, mt[3]);
        chk(irq, 1'b1);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h3);
        chk(irq, 1'b0);
        // done event unmasked, hit recorded in the high word
        wb(1'b1, 8'h24, 32'h2);
        conv(5'd17, mt[3]);
        chk(hit, 32'h0002_0004);
        chk(irq, 1'b1);
        wb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0002);
        chk(hit, 32'h0000_0004);
        wb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h3);
        chk(irq, 1'b0);
        $display("interrupt done");
        // a code past the external inputs still reaches the multiplexer
        wb(1'b1, 8'h00, 32'h001e);
        chk(pos, 5'h1e);
        conclude();
    end
endmodule
`default_nettype wire
